//--- hw/crcpc_top.v
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "crcpc_consts.vh"

module crcpc_top #(
  parameter ADDR_W = 4
) (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [31:0] data_q;
  reg [31:0] poly_q;
  reg [31:0] ctrl_q;
  reg [31:0] mid_q;
  reg half_q;

  wire [1:0] wr_xp = ctrl_q[`CRCPC_CTL_WXP_HI:`CRCPC_CTL_WXP_LO];
  wire [1:0] rd_xp = ctrl_q[`CRCPC_CTL_RXP_HI:`CRCPC_CTL_RXP_LO];
  wire cmpl_en = ctrl_q[`CRCPC_CTL_CMPL];
  wire seed_sel = ctrl_q[`CRCPC_CTL_SEED];
  wire width_sel_32 = ctrl_q[`CRCPC_CTL_W32];

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire hit_data = (PADDR == `CRCPC_OFS_DATA);
  wire hit_poly = (PADDR == `CRCPC_OFS_POLY);
  wire hit_ctrl = (PADDR == `CRCPC_OFS_CTRL);
  wire hit_any = hit_data | hit_poly | hit_ctrl;

  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  wire wr_acc = access & PWRITE & hit_any;
  wire data_feed = access & PWRITE & hit_data & ~seed_sel;

  // a message write holds the access phase for one extra cycle
  assign PREADY = ~(data_feed & ~half_q);
  assign PSLVERR = access & ~hit_any;

  wire done = access & PREADY;

  // ----------------------------------------
  // write data path
  // ----------------------------------------
  wire [31:0] lane_mask;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
      assign lane_mask[gb*8 +: 8] = {8{PSTRB[gb]}};
    end
  endgenerate

  // ----------------------------------------
  // write transform
  // ----------------------------------------
  // unused lanes are zero before the transform
  wire [31:0] wr_raw = PWDATA & lane_mask;
  wire [31:0] wr_bitrev;
  wire [31:0] wr_fullrev;
  reg [31:0] wr_word;
  reg [3:0] wr_valid;

  genvar gw;
  generate
    for (gw = 0; gw < 32; gw = gw + 1) begin : g_wr_bit
      assign wr_bitrev[gw] = wr_raw[(gw / 8) * 8 + 7 - (gw % 8)];
      assign wr_fullrev[gw] = wr_raw[31 - gw];
    end
  endgenerate

  // strobes follow the data whenever whole bytes move
  always @* begin
    case (wr_xp)
      `CRCPC_XP_BITS: begin
        wr_word = wr_bitrev;
        wr_valid = PSTRB;
      end
      `CRCPC_XP_BOTH: begin
        wr_word = wr_fullrev;
        wr_valid = {PSTRB[0], PSTRB[1], PSTRB[2], PSTRB[3]};
      end
      `CRCPC_XP_BYTES: begin
        wr_word = {wr_raw[7:0], wr_raw[15:8], wr_raw[23:16], wr_raw[31:24]};
        wr_valid = {PSTRB[0], PSTRB[1], PSTRB[2], PSTRB[3]};
      end
      default: begin
        wr_word = wr_raw;
        wr_valid = PSTRB;
      end
    endcase
  end

  // ----------------------------------------
  // byte engine, two bytes a cycle
  // ----------------------------------------
  wire [31:0] step_a_in = half_q ? mid_q : data_q;
  wire [7:0] byte_a = half_q ? wr_word[15:8] : wr_word[31:24];
  wire [7:0] byte_b = half_q ? wr_word[7:0] : wr_word[23:16];
  wire use_a = half_q ? wr_valid[1] : wr_valid[3];
  wire use_b = half_q ? wr_valid[0] : wr_valid[2];
  wire [31:0] step_a_out;
  wire [31:0] step_b_out;

  // most significant byte is folded first
  crcpc_byte_step u_step_a (
    .crc_in(step_a_in),
    .crc_out(step_a_out),
    .byte_in(byte_a),
    .use_byte(use_a),
    .poly(poly_q),
    .wide(width_sel_32)
  );

  crcpc_byte_step u_step_b (
    .crc_in(step_a_out),
    .crc_out(step_b_out),
    .byte_in(byte_b),
    .use_byte(use_b),
    .poly(poly_q),
    .wide(width_sel_32)
  );

  // ----------------------------------------
  // two-cycle update sequencing
  // ----------------------------------------
  localparam ST_HEAD = 1'b0;
  localparam ST_TAIL = 1'b1;

  reg half_d;
  reg [31:0] mid_d;

  // lanes 3 and 2 fold in the first cycle, lanes 1 and 0 in the second
  always @* begin
    half_d = half_q;
    mid_d = mid_q;
    case (half_q)
      ST_HEAD: begin
        if (data_feed) begin
          half_d = ST_TAIL;
          mid_d = step_b_out;
        end
      end
      ST_TAIL: begin
        // the tail cycle always completes the access
        half_d = ST_HEAD;
      end
      default: begin
        half_d = ST_HEAD;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      half_q <= ST_HEAD;
      mid_q <= 32'h00000000;
    end else begin
      half_q <= half_d;
      mid_q <= mid_d;
    end
  end

  // ----------------------------------------
  // data register: seed or checksum
  // ----------------------------------------
  reg [31:0] data_d;
  wire seed_wr = wr_acc & hit_data & seed_sel;
  wire [3:0] seed_we;
  wire [31:0] seed_next;

  genvar gs;
  generate
    for (gs = 0; gs < 4; gs = gs + 1) begin : g_seed_lane
      // 16-bit width seeds only the low two bytes
      if (gs < 2) begin : g_low
        assign seed_we[gs] = seed_wr & wr_valid[gs];
      end else begin : g_high
        assign seed_we[gs] = seed_wr & wr_valid[gs] & width_sel_32;
      end
      assign seed_next[gs*8 +: 8] = seed_we[gs] ? wr_word[gs*8 +: 8] : data_q[gs*8 +: 8];
    end
  endgenerate

  always @* begin
    data_d = data_q;
    if (seed_wr) begin
      data_d = seed_next;
    end else if (data_feed & half_q) begin
      data_d = step_b_out;
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_q <= `CRCPC_RST_DATA;
    end else begin
      data_q <= data_d;
    end
  end

  // ----------------------------------------
  // polynomial register
  // ----------------------------------------
  reg [31:0] poly_d;

  always @* begin
    poly_d = poly_q;
    if (wr_acc & hit_poly) begin
      if (PSTRB[0]) begin
        poly_d[7:0] = PWDATA[7:0];
      end
      if (PSTRB[1]) begin
        poly_d[15:8] = PWDATA[15:8];
      end
      // upper half is frozen while the width is 16
      if (width_sel_32) begin
        if (PSTRB[2]) begin
          poly_d[23:16] = PWDATA[23:16];
        end
        if (PSTRB[3]) begin
          poly_d[31:24] = PWDATA[31:24];
        end
      end
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      poly_q <= `CRCPC_RST_POLY;
    end else begin
      poly_q <= poly_d;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg [31:0] ctrl_d;

  always @* begin
    ctrl_d = ctrl_q;
    if (wr_acc & hit_ctrl & PSTRB[3]) begin
      // only the defined upper bits take the write
      ctrl_d = PWDATA & `CRCPC_CTL_WMASK;
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= `CRCPC_RST_CTRL;
    end else begin
      ctrl_q <= ctrl_d & `CRCPC_CTL_WMASK;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // complement and transform commute, so order is free
  wire [31:0] rd_raw = cmpl_en ? ~data_q : data_q;
  wire [31:0] rd_bitrev;
  wire [31:0] rd_fullrev;
  reg [31:0] data_rd;

  genvar gr;
  generate
    for (gr = 0; gr < 32; gr = gr + 1) begin : g_rd_bit
      assign rd_bitrev[gr] = rd_raw[(gr / 8) * 8 + 7 - (gr % 8)];
      assign rd_fullrev[gr] = rd_raw[31 - gr];
    end
  endgenerate

  // a 16-bit result moves to the upper half in the byte swapping modes
  always @* begin
    case (rd_xp)
      `CRCPC_XP_BITS: begin
        data_rd = rd_bitrev;
      end
      `CRCPC_XP_BOTH: begin
        data_rd = rd_fullrev;
      end
      `CRCPC_XP_BYTES: begin
        data_rd = {rd_raw[7:0], rd_raw[15:8], rd_raw[23:16], rd_raw[31:24]};
      end
      default: begin
        data_rd = rd_raw;
      end
    endcase
  end

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_data) begin
      rd_mux = data_rd;
    end else if (hit_poly) begin
      rd_mux = poly_q;
    end else if (hit_ctrl) begin
      rd_mux = ctrl_q & `CRCPC_CTL_WMASK;
    end
  end

  // read data is caught in the setup cycle, held through the access
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else begin
      if (setup & ~PWRITE) begin
        PRDATA <= rd_mux;
      end else if (done) begin
        PRDATA <= 32'h00000000;
      end
    end
  end

endmodule // crcpc_top

`default_nettype wire

//--- common/crcpc_consts.vh
// Overview of operation
// - poly bits 31..16 live in the upper half and feed the engine only in 32-bit width.
// - in 16-bit width writes to the upper poly half are dropped and it keeps its value.
// - poly bits 15..0 live in the lower half, always writable, always used.
// - control bit 24 picks the width, 0 for 16-bit and 1 for 32-bit.
// - control bits 31:30 pick the write transform: none, bits, bits and bytes, bytes.
// - control bits 29:28 pick the same four transforms for data register reads.
// - control bit 26 makes data register reads return the complement of the checksum.
// - control bit 25 set makes data writes load the seed, clear makes them message data.
// - control bit 27 and bits 23:0 read as zero and ignore writes.
// - each message data write updates the checksum, which is stored back in the data register.
// - in 16-bit width the seed and the result use only the low two data bytes.
// - the checksum advances two bytes a clock cycle and one update takes two clock cycles.
// - short writes are zero padded for the transform, but only valid bytes are summed.
`ifndef CRCPC_CONSTS_VH
`define CRCPC_CONSTS_VH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define CRCPC_OFS_DATA 4'h0
`define CRCPC_OFS_POLY 4'h4
`define CRCPC_OFS_CTRL 4'h8

// ----------------------------------------
// reset values
// ----------------------------------------
`define CRCPC_RST_DATA 32'hffffffff
`define CRCPC_RST_POLY 32'h00001021
`define CRCPC_RST_CTRL 32'h00000000

// ----------------------------------------
// control fields
// ----------------------------------------
`define CRCPC_CTL_WXP_HI 31
`define CRCPC_CTL_WXP_LO 30
`define CRCPC_CTL_RXP_HI 29
`define CRCPC_CTL_RXP_LO 28
`define CRCPC_CTL_CMPL 26
`define CRCPC_CTL_SEED 25
`define CRCPC_CTL_W32 24
`define CRCPC_CTL_WMASK 32'hf7000000

// ----------------------------------------
// transform codes
// ----------------------------------------
`define CRCPC_XP_NONE 2'h0
`define CRCPC_XP_BITS 2'h1
`define CRCPC_XP_BOTH 2'h2
`define CRCPC_XP_BYTES 2'h3

`endif

//--- hw/crcpc_byte_step.v
`timescale 1ns/1ps
`default_nettype none

// one byte of the shift register, eight shifts unrolled
module crcpc_byte_step (
  // checksum in and out
  input wire [31:0] crc_in,
  output reg [31:0] crc_out,
  // byte to fold in
  input wire [7:0] byte_in,
  input wire use_byte,
  // setup
  input wire [31:0] poly,
  input wire wide
);

  integer i;
  reg [31:0] c;
  reg [31:0] taps;
  reg fb;

  always @* begin
    c = crc_in;
    fb = 1'b0;
    taps = wide ? poly : {16'h0000, poly[15:0]};
    if (wide) begin
      c[31:24] = c[31:24] ^ byte_in;
    end else begin
      c[15:8] = c[15:8] ^ byte_in;
    end
    for (i = 0; i < 8; i = i + 1) begin
      // shifted-out msb stands for the implicit top term
      if (wide) begin
        fb = c[31];
        c = {c[30:0], 1'b0};
        if (fb) begin
          c = c ^ taps;
        end
      end else begin
        fb = c[15];
        c[15:0] = {c[14:0], 1'b0};
        if (fb) begin
          c[15:0] = c[15:0] ^ taps[15:0];
        end
      end
    end
    crc_out = use_byte ? c : crc_in;
  end

endmodule // crcpc_byte_step

`default_nettype wire

//--- sim/crcpc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "crcpc_consts.vh"
module crcpc_monitor #(
  parameter ADDR_W = 4
) (
  // apb slave as seen at the block
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  logic [31:0] ctrl_q;
  logic [31:0] poly_q;
  logic dhi_ok_q;
  wire acc = PSEL && PENABLE;
  wire wr_done = acc && PREADY && PWRITE;
  wire rd_done = acc && PREADY && !PWRITE;
  wire msg = acc && PWRITE && PADDR == `CRCPC_OFS_DATA;
  // ----------------------------------------
  // shadow of what software wrote
  // ----------------------------------------
  // upper data bytes stay known only until a 32-bit data write
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= `CRCPC_RST_CTRL;
      poly_q <= `CRCPC_RST_POLY;
      dhi_ok_q <= 1'b1;
    end else if (wr_done) begin
      if (PADDR == `CRCPC_OFS_CTRL && PSTRB[3])
        ctrl_q <= PWDATA & `CRCPC_CTL_WMASK;
      if (PADDR == `CRCPC_OFS_POLY)
        for (int i = 0; i < 4; i++)
          if (PSTRB[i] && (i < 2 || ctrl_q[`CRCPC_CTL_W32]))
            poly_q[8*i+:8] <= PWDATA[8*i+:8];
      if (PADDR == `CRCPC_OFS_DATA && ctrl_q[`CRCPC_CTL_W32])
        dhi_ok_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_rsvd_zero: assert property (
    rd_done && PADDR == `CRCPC_OFS_CTRL |-> (PRDATA & ~`CRCPC_CTL_WMASK) == 32'h0)
    else $error("reserved control bits read nonzero");
  a_ctrl_readback: assert property (
    rd_done && PADDR == `CRCPC_OFS_CTRL |-> PRDATA == ctrl_q)
    else $error("control readback differs");
  a_poly_hi_kept: assert property (
    rd_done && PADDR == `CRCPC_OFS_POLY |-> PRDATA[31:16] == poly_q[31:16])
    else $error("upper polynomial half wrong");
  a_poly_lo_rw: assert property (
    rd_done && PADDR == `CRCPC_OFS_POLY |-> PRDATA[15:0] == poly_q[15:0])
    else $error("lower polynomial half wrong");
  a_msg_two_clk: assert property (
    msg && !ctrl_q[`CRCPC_CTL_SEED] && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("message write not one wait state");
  a_seed_no_wait: assert property (
    msg && ctrl_q[`CRCPC_CTL_SEED] |-> PREADY)
    else $error("seed write stalled");
  a_data_hi_16: assert property (
    rd_done && PADDR == `CRCPC_OFS_DATA && dhi_ok_q && ctrl_q[29:26] == 4'h0
    |-> PRDATA[31:16] == 16'hffff)
    else $error("upper data bytes changed in 16-bit width");
  a_err_decode: assert property (
    acc |-> PSLVERR == !(PADDR inside {`CRCPC_OFS_DATA, `CRCPC_OFS_POLY, `CRCPC_OFS_CTRL}))
    else $error("error response decode wrong");
endmodule // crcpc_monitor

bind crcpc_top crcpc_monitor #(.ADDR_W(ADDR_W)) u_mon (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "crcpc_consts.vh"
module tb_top;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} crcpc_row_t;
  logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, rerr;
  logic [3:0] PADDR, PSTRB;
  logic [31:0] PWDATA, PRDATA, rdat, m_ctrl, m_poly, m_data;
  int fail_count, num_checks;
  logic [3:0] sl [4] = '{4'hf, 4'h1, 4'h3, 4'hc};
  crcpc_row_t rows [7] = '{'{4'h8, 32'hffffffff, 32'hf7000000}, '{4'h8, 32'h0, 32'h0},
    '{4'h4, 32'hffffffff, 32'h0000ffff}, '{4'h8, 32'h01000000, 32'h01000000},
    '{4'h4, 32'h04c11db7, 32'h04c11db7}, '{4'h8, 32'h03000000, 32'h03000000},
    '{4'h0, 32'h12345678, 32'h12345678}};
  crcpc_top u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [31:0] xp(input logic [31:0] v, input logic [1:0] m);
    logic [31:0] b;
    for (int i = 0; i < 32; i++) b[i] = v[(i & 24) + 7 - (i & 7)];
    case (m)
      2'h1: xp = b;
      2'h2: xp = {b[7:0], b[15:8], b[23:16], b[31:24]};
      2'h3: xp = {v[7:0], v[15:8], v[23:16], v[31:24]};
      default: xp = v;
    endcase
  endfunction
  function automatic logic [31:0] upd(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = m_ctrl[24] ? c ^ {b, 24'h0} : {c[31:16], c[15:0] ^ {b, 8'h0}};
    for (int k = 0; k < 8; k++)
      if (m_ctrl[24]) r = r[31] ? (r << 1) ^ m_poly : r << 1;
      else r[15:0] = r[15] ? (r[15:0] << 1) ^ m_poly[15:0] : r[15:0] << 1;
    return r;
  endfunction
  // short writes: lanes zeroed before the transform, strobes follow byte swaps
  function automatic void mwr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] x;
    logic [3:0] t;
    if (a == `CRCPC_OFS_CTRL && s[3]) m_ctrl = d & `CRCPC_CTL_WMASK;
    if (a == `CRCPC_OFS_POLY) m_poly = {m_ctrl[24] ? d[31:16] : m_poly[31:16], d[15:0]};
    if (a != `CRCPC_OFS_DATA) return;
    x = xp(d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}}, m_ctrl[31:30]);
    t = m_ctrl[31] ? {s[0], s[1], s[2], s[3]} : s;
    if (m_ctrl[25]) m_data = m_ctrl[24] ? x : {m_data[31:16], x[15:0]};
    else for (int i = 3; i >= 0; i--) if (t[i]) m_data = upd(m_data, x[8*i+:8]);
  endfunction
  // ----------------------------------------
  // apb master and checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // leaves the bus selected so a setup may follow at once
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d; PSTRB <= s;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1 && n < 20) begin
      n++;
      @(posedge REF_CLK);
    end
    if (n == 20) fail_count++;
    rdat = PRDATA;
    rerr = PSLVERR;
  endtask
  task automatic idle;
    PSEL <= 1'b0; PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s); idle(); mwr(a, d, s);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0); idle(); chk(rdat, e);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    RST_N = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 4'h0;
    PWDATA = 32'h0; PSTRB = 4'h0; fail_count = 0; num_checks = 0;
    m_ctrl = `CRCPC_RST_CTRL; m_poly = `CRCPC_RST_POLY; m_data = `CRCPC_RST_DATA;
    repeat (6) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 4'hf);
      rd(rows[i].a, rows[i].e);
    end
    // every write and read transform, complement, width and short strobes
    for (int k = 0; k < 32; k++) begin
      wr(4'h8, {k[3:0], 1'b0, k[2], 1'b1, k[4], 24'h0}, 4'hf);
      wr(4'h0, 32'h89abcdef + k, 4'hf);
      wr(4'h8, {k[3:0], 1'b0, k[2], 1'b0, k[4], 24'h0}, 4'hf);
      apb(1'b1, 4'h0, 32'h31323334 ^ k, 4'hf); mwr(4'h0, 32'h31323334 ^ k, 4'hf);
      apb(1'b1, 4'h0, 32'hc0ffee00 + k, sl[k[1:0]]); mwr(4'h0, 32'hc0ffee00 + k, sl[k[1:0]]);
      idle();
      rd(4'h0, xp(m_ctrl[26] ? ~m_data : m_data, m_ctrl[29:28]));
    end
    wr(4'h8, 32'h0, 4'h7);
    rd(4'h8, m_ctrl);
    apb(1'b1, 4'hc, 32'hffffffff, 4'hf);
    idle();
    chk({31'h0, rerr}, 32'h1);
    rd(4'h8, m_ctrl);
    RST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    m_ctrl = `CRCPC_RST_CTRL; m_poly = `CRCPC_RST_POLY; m_data = `CRCPC_RST_DATA;
    rd(4'h0, `CRCPC_RST_DATA);
    rd(4'h4, `CRCPC_RST_POLY);
    rd(4'h8, `CRCPC_RST_CTRL);
    wr(4'h8, 32'h02000000, 4'hf);
    wr(4'h0, 32'h12345678, 4'hf);
    rd(4'h0, 32'hffff5678);
    wr(4'h8, 32'h0, 4'hf);
    wr(4'h0, 32'ha5a55a5a, 4'hf);
    rd(4'h0, m_data);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
